/* hdl/serial_core_params.svh */
/*
 Register offsets, field positions, reset values and counts for the serial core.
 Assumes inclusion by bare name from the core module only.
*/
`ifndef SERIAL_CORE_PARAMS_SVH
`define SERIAL_CORE_PARAMS_SVH
`define OFS_CTRL1 3'h0
`define OFS_CTRL2 3'h1
`define OFS_CTRL3 3'h2
`define OFS_STAT1 3'h3
`define OFS_STAT2 3'h4
`define OFS_DATA 3'h5
`define OFS_BAUD 3'h6
`define OFS_IRCTL 3'h7
`define C1_MODULE_ON 6
`define C1_CHAR9 4
`define C2_TXE_IE 7
`define C2_TXD_IE 6
`define C2_RXF_IE 5
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_BRK 0
`define C3_RX9 7
`define C3_TX9 6
`define S1_TXE 7
`define S1_TXD 6
`define S1_RXF 5
`define S1_NF 2
`define S1_FE 1
`define S2_BRK 1
`define S2_RXACT 0
`define BR_SRC 7
`define BR_DIV_MSB 5
`define IR_ON 0
`define IR_CNT_HOLD 4'h7
`define IR_CNT_LAST 4'hf
`define RT_LAST 4'hf
`define RST_CTRL 8'h00
`define LEN_CHAR8 4'ha
`define LEN_CHAR9 4'hb
`endif

/* hdl/serial_core_pkg.sv */
/*
 Types shared by the serial core: state enums and the register port carrier.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_core_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DATA = 2'b01,
        TX_BRK = 2'b10,
        TX_FILL = 2'b11
    } tx_state_t;
    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } rx_state_t;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage : serial_core_pkg

/* hdl/infrared_async_serial_core.sv */
/*
 Serial transmitter and receiver with infrared receive decoder, baud generator and register port.
 Assumes a synchronous register master, synchronous pin inputs and an open-drain pull-up on the transmit pin.
*/
`timescale 1ns/1ps
`include "serial_core_params.svh"
module infrared_async_serial_core
    import serial_core_pkg::*;
(
    input wire logic core_clk, // 50 MHz core clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire bus_req_t bus_req, // register request
    output logic [7:0] rd_data, // read data, cycle after read strobe
    input wire logic alt_src_tick, // one-cycle ticks of the alternate baud source
    input wire logic rx_pin_in, // receive pin level
    output logic tx_pin_out, // transmit pin drive value
    output logic tx_pin_oe, // transmit pin driven low while high
    output logic tx_irq, // transmitter interrupt request
    output logic rx_irq // receiver interrupt request
);
    logic serial_module_on, char9, tx_empty_irq_on, tx_done_irq_on, rx_full_irq_on;
    logic tx_on, rx_on, send_brk, tx_ninth_bit, baud_src_sel, ir_on;
    logic [`BR_DIV_MSB:0] baud_div;
    logic [7:0] tx_buf, rx_data;
    logic rx_ninth_bit, tx_buffer_empty, tx_done_flag, rx_buffer_full;
    logic noise_flag, framing_flag, break_seen, stat1_armed, stat2_armed;
    logic [`BR_DIV_MSB:0] div_cnt;
    logic tick32, tick16, half;
    logic rx_prev, ir_pend, ir_run, ir_jit, decoded_rx_line;
    logic [3:0] ir_cnt;
    logic ir_pulse, rx_line;
    tx_state_t tx_state, tx_next;
    logic [10:0] tx_shift;
    logic [3:0] tx_left, tx_rt, frame_len;
    logic idle_q, tx_on_prev, tx_bit, tx_slot, load_data;
    rx_state_t rx_state;
    logic [3:0] rt;
    logic [2:0] hist;
    logic [1:0] smp;
    logic [8:0] rx_shift;
    logic [3:0] bitcnt;
    logic last_bit, rx_noise;
    logic bit_val, frame_done, frame_brk, data_rd, data_wr, stat1_rd;

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction : maj3

    function automatic logic split3(input logic a, input logic b, input logic c);
        split3 = !((a == b) && (b == c));
    endfunction : split3

    assign data_rd = bus_req.rd && bus_req.addr == `OFS_DATA;
    assign data_wr = bus_req.wr && bus_req.addr == `OFS_DATA;
    assign stat1_rd = bus_req.rd && bus_req.addr == `OFS_STAT1;

    // Control registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {serial_module_on, char9} <= 2'h0;
            {tx_empty_irq_on, tx_done_irq_on, rx_full_irq_on, tx_on, rx_on, send_brk} <= 6'h00;
            {tx_ninth_bit, baud_src_sel, ir_on} <= 3'h0;
            baud_div <= '0;
            tx_buf <= `RST_CTRL;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `OFS_CTRL1: begin
                    serial_module_on <= bus_req.wdata[`C1_MODULE_ON];
                    char9 <= bus_req.wdata[`C1_CHAR9];
                end
                `OFS_CTRL2: begin
                    tx_empty_irq_on <= bus_req.wdata[`C2_TXE_IE];
                    tx_done_irq_on <= bus_req.wdata[`C2_TXD_IE];
                    rx_full_irq_on <= bus_req.wdata[`C2_RXF_IE];
                    tx_on <= bus_req.wdata[`C2_TX_ON];
                    rx_on <= bus_req.wdata[`C2_RX_ON];
                    send_brk <= bus_req.wdata[`C2_BRK];
                end
                `OFS_CTRL3: tx_ninth_bit <= bus_req.wdata[`C3_TX9];
                `OFS_DATA: tx_buf <= bus_req.wdata;
                `OFS_BAUD: begin
                    baud_src_sel <= bus_req.wdata[`BR_SRC];
                    baud_div <= bus_req.wdata[`BR_DIV_MSB:0];
                end
                `OFS_IRCTL: ir_on <= bus_req.wdata[`IR_ON];
                default: ;
            endcase
        end
    end

    // Read port: data only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst || !bus_req.rd) begin
            rd_data <= 8'h00;
        end else begin
            case (bus_req.addr)
                `OFS_CTRL1: rd_data <= {1'b0, serial_module_on, 1'b0, char9, 4'h0};
                `OFS_CTRL2: rd_data <= {tx_empty_irq_on, tx_done_irq_on, rx_full_irq_on, 1'b0,
                                        tx_on, rx_on, 1'b0, send_brk};
                `OFS_CTRL3: rd_data <= {rx_ninth_bit, tx_ninth_bit, 6'h00};
                `OFS_STAT1: rd_data <= {tx_buffer_empty, tx_done_flag, rx_buffer_full, 2'h0,
                                        noise_flag, framing_flag, 1'b0};
                `OFS_STAT2: rd_data <= {6'h00, break_seen, rx_state != RX_HUNT};
                `OFS_DATA: rd_data <= rx_data;
                `OFS_BAUD: rd_data <= {baud_src_sel, 1'b0, baud_div};
                default: rd_data <= {7'h00, ir_on};
            endcase
        end
    end

    // Baud generator: 32x tick from the chosen source, 16x on every second one
    always_ff @(posedge core_clk) begin
        if (sys_rst || !serial_module_on) begin
            div_cnt <= '0;
            {tick32, tick16, half} <= 3'h0;
        end else begin
            tick32 <= 1'b0;
            tick16 <= 1'b0;
            if (baud_src_sel ? alt_src_tick : 1'b1) begin
                if (div_cnt == baud_div) begin
                    div_cnt <= '0;
                    tick32 <= 1'b1;
                    half <= ~half;
                    tick16 <= half;
                end else begin
                    div_cnt <= div_cnt + 1'b1;
                end
            end
        end
    end

    // Infrared decoder: catch narrow pulses between 16x ticks
    assign ir_pulse = ir_pend || (rx_prev && !rx_pin_in);
    assign rx_line = ir_on ? decoded_rx_line : rx_pin_in;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_prev <= 1'b1;
            ir_pend <= 1'b0;
            ir_run <= 1'b0;
            ir_jit <= 1'b0;
            ir_cnt <= 4'h0;
            decoded_rx_line <= 1'b1;
        end else begin
            rx_prev <= rx_pin_in;
            if (tick16) begin
                ir_pend <= 1'b0;
                if (!ir_run) begin
                    ir_jit <= 1'b0;
                    if (ir_pulse && !ir_jit) begin
                        ir_run <= 1'b1;
                        ir_cnt <= 4'h0;
                        decoded_rx_line <= 1'b0;
                    end
                end else if (ir_pulse && ir_cnt > `IR_CNT_HOLD) begin
                    ir_cnt <= 4'h0;
                end else if (ir_cnt == `IR_CNT_LAST) begin
                    ir_run <= 1'b0;
                    ir_jit <= 1'b1;
                    decoded_rx_line <= 1'b1;
                end else begin
                    ir_cnt <= ir_cnt + 1'b1;
                end
            end else if (rx_prev && !rx_pin_in) begin
                ir_pend <= 1'b1;
            end
        end
    end

    // Transmitter: pick the next character at each character boundary
    assign frame_len = char9 ? `LEN_CHAR9 : `LEN_CHAR8;
    assign tx_slot = tick16 && (tx_state == TX_IDLE || (tx_rt == `RT_LAST && tx_left == 4'h1));
    assign tx_bit = (tx_state == TX_IDLE) ? 1'b1 : tx_shift[0];

    always_comb begin
        if (send_brk && tx_on) begin
            tx_next = TX_BRK;
        end else if (idle_q) begin
            tx_next = TX_FILL;
        end else if (tx_on && tx_on_prev && !tx_buffer_empty) begin
            tx_next = TX_DATA;
        end else begin
            tx_next = TX_IDLE;
        end
    end
    assign load_data = tx_slot && tx_next == TX_DATA;

    always_ff @(posedge core_clk) begin
        if (sys_rst || !serial_module_on) begin
            tx_state <= TX_IDLE;
            tx_shift <= 11'h7ff;
            {tx_left, tx_rt} <= 8'h00;
            idle_q <= 1'b0;
            tx_on_prev <= 1'b0;
        end else begin
            tx_on_prev <= tx_on;
            if (tick16 && tx_state != TX_IDLE) begin
                tx_rt <= tx_rt + 1'b1;
                if (tx_rt == `RT_LAST) begin
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    tx_left <= tx_left - 1'b1;
                end
            end
            if (tx_slot) begin
                tx_state <= tx_next;
                tx_rt <= 4'h0;
                tx_left <= frame_len;
                case (tx_next)
                    TX_BRK: tx_shift <= 11'h000;
                    TX_FILL: tx_shift <= 11'h7ff;
                    TX_DATA: tx_shift <= {1'b1, char9 ? tx_ninth_bit : 1'b1, tx_buf, 1'b0};
                    default: tx_shift <= 11'h7ff;
                endcase
            end
            // Set wins over the clear taken when the fill character starts
            if (tx_on && !tx_on_prev) begin
                idle_q <= 1'b1;
            end else if (tx_slot && tx_state == TX_BRK && !send_brk) begin
                idle_q <= 1'b1;
            end else if (tx_slot && tx_next == TX_FILL) begin
                idle_q <= 1'b0;
            end
        end
    end

    // Transmit flags; hand-over set wins over the software clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_buffer_empty <= 1'b1;
            tx_done_flag <= 1'b1;
            stat1_armed <= 1'b0;
        end else begin
            if (stat1_rd) begin
                stat1_armed <= 1'b1;
            end else if (data_wr || data_rd) begin
                stat1_armed <= 1'b0;
            end
            if (load_data) begin
                tx_buffer_empty <= 1'b1;
            end else if (data_wr && stat1_armed) begin
                tx_buffer_empty <= 1'b0;
            end
            tx_done_flag <= tx_state == TX_IDLE && tx_buffer_empty && !idle_q && !send_brk;
        end
    end

    // Receiver: majority of RT3, RT5, RT7 for the start bit, of RT8, RT9, RT10 for later bits, on the 16x sampling clock
    assign bit_val = maj3(smp[0], smp[1], rx_line);
    assign frame_done = tick16 && rx_state == RX_BITS && rt == 4'ha && bitcnt == (char9 ? 4'h9 : 4'h8);
    assign frame_brk = !bit_val && rx_shift == 9'h000;

    always_ff @(posedge core_clk) begin
        if (sys_rst || !serial_module_on || !rx_on) begin
            rx_state <= RX_HUNT;
            rt <= 4'h0;
            hist <= 3'h0;
            smp <= 2'h0;
            bitcnt <= 4'h0;
            {last_bit, rx_noise} <= 2'h0;
            rx_shift <= 9'h000;
        end else if (tick16) begin
            hist <= {hist[1:0], rx_line};
            rt <= rt + 1'b1;
            case (rx_state)
                RX_HUNT: begin
                    if (hist == 3'h7 && !rx_line) begin
                        rx_state <= RX_START;
                        rt <= 4'h1;
                        rx_noise <= 1'b0;
                        rx_shift <= 9'h000;
                    end
                end
                RX_START: begin
                    if (rt == 4'h3) smp[0] <= rx_line;
                    if (rt == 4'h5) smp[1] <= rx_line;
                    if (rt == 4'h7) begin
                        if (maj3(smp[0], smp[1], rx_line)) begin
                            rx_state <= RX_HUNT;
                        end else begin
                            rx_noise <= split3(smp[0], smp[1], rx_line);
                        end
                    end
                    if (rt == 4'h0) begin
                        rx_state <= RX_BITS;
                        bitcnt <= 4'h0;
                        last_bit <= 1'b0;
                    end
                end
                RX_BITS: begin
                    if (rt == 4'h8) smp[0] <= rx_line;
                    if (rt == 4'h9) smp[1] <= rx_line;
                    if (rt == 4'ha) begin
                        last_bit <= bit_val;
                        bitcnt <= bitcnt + 1'b1;
                        if (bitcnt < 4'h9) rx_shift[bitcnt] <= bit_val;
                        if (split3(smp[0], smp[1], rx_line)) rx_noise <= 1'b1;
                        if (frame_done) begin
                            rx_state <= RX_HUNT;
                            hist <= bit_val ? 3'h7 : 3'h0;
                        end
                    end else if ((rt > 4'ha || rt == 4'h0) && last_bit && hist[0] && !rx_line) begin
                        rt <= 4'h1;
                    end
                end
                default: rx_state <= RX_HUNT;
            endcase
        end
    end

    // Receive buffer and flags; a new character wins over the read clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_data <= 8'h00;
            rx_ninth_bit <= 1'b0;
            {rx_buffer_full, noise_flag, framing_flag, break_seen, stat2_armed} <= 5'h00;
        end else begin
            if (bus_req.rd && bus_req.addr == `OFS_STAT2) begin
                stat2_armed <= 1'b1;
            end else if (data_rd) begin
                stat2_armed <= 1'b0;
            end
            if (data_rd && stat1_armed) begin
                {rx_buffer_full, noise_flag, framing_flag} <= 3'h0;
            end
            if (data_rd && stat2_armed) begin
                break_seen <= 1'b0;
            end
            if (frame_done) begin
                rx_buffer_full <= 1'b1;
                framing_flag <= !bit_val;
                noise_flag <= rx_noise || split3(smp[0], smp[1], rx_line);
                rx_data <= frame_brk ? 8'h00 : rx_shift[7:0];
                rx_ninth_bit <= frame_brk ? 1'b0 : (char9 ? rx_shift[8] : rx_shift[7]);
                if (frame_brk) break_seen <= 1'b1;
            end
        end
    end

    // Pin and interrupt outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {tx_pin_out, tx_pin_oe, tx_irq, rx_irq} <= 4'h0;
        end else begin
            tx_pin_out <= 1'b0;
            tx_pin_oe <= serial_module_on && !tx_bit;
            tx_irq <= (tx_buffer_empty && tx_empty_irq_on) || (tx_done_flag && tx_done_irq_on);
            rx_irq <= rx_buffer_full && rx_full_irq_on;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    ir_hold_low_a: assert property (ir_run && ir_cnt <= `IR_CNT_HOLD |-> !decoded_rx_line)
        else $error("decoder output high during hold window");
    ir_release_a: assert property ($rose(decoded_rx_line) |-> !ir_run && $past(ir_cnt) == `IR_CNT_LAST)
        else $error("decoder released before count fifteen");
    ir_start_a: assert property (tick16 && !ir_run && ir_pulse && !ir_jit |=> ir_run && ir_cnt == 4'h0 && !decoded_rx_line)
        else $error("decoder did not start on pulse");
    tx_idle_pin_a: assert property (tx_state == TX_IDLE |=> !tx_pin_oe)
        else $error("transmit pin driven while idle");
    module_off_a: assert property (!serial_module_on |=> tx_state == TX_IDLE ##1 !tx_pin_oe)
        else $error("pin held with module off");
    tx_empty_set_a: assert property (load_data |=> tx_buffer_empty && tx_state == TX_DATA)
        else $error("empty flag missed on hand-over");
    frame_bits_a: assert property (load_data |=> !tx_shift[0] && tx_shift[10])
        else $error("start or stop bit wrong");
    preamble_first_a: assert property (tx_on && !tx_on_prev |-> !load_data ##1 !load_data)
        else $error("data loaded before preamble");
    tx_irq_gate_a: assert property (1'b1 |=> tx_irq == $past((tx_buffer_empty && tx_empty_irq_on)
        || (tx_done_flag && tx_done_irq_on)))
        else $error("transmit interrupt not gated");
    rx_break_a: assert property (frame_done && frame_brk |=> rx_buffer_full && break_seen && framing_flag
        && rx_data == 8'h00 && !rx_ninth_bit)
        else $error("break effects missing");

    data_sent_c: cover property (load_data ##[1:400] tx_state == TX_IDLE);
    break_rx_c: cover property (frame_done && frame_brk);
    ir_release_c: cover property ($rose(decoded_rx_line));
endmodule : infrared_async_serial_core

/* sim/serial_peer_model.sv */
/*
 Remote serial device: drives the receive line, optionally as narrow infrared pulses, and decodes the transmit pin.
 Assumes an open-drain transmit pin with pull-up and a bit time given in core clocks.
*/
`timescale 1ns/1ps
module serial_peer_model (
    input wire logic core_clk, // core clock
    input wire logic tx_pin_oe, // device pulls its pin low while high
    output logic line_out // receive line toward the device
);
    logic [7:0] got_q[$];
    int rx_bit = 32;
    logic wire_lvl;
    assign wire_lvl = !tx_pin_oe;
    initial line_out = 1'b1;
    // Frame LSB first; in infrared mode a zero bit is a low pulse of one sixteenth bit
    task automatic send(input logic [9:0] bits, input int bit_cyc, input bit ir);
        for (int i = 0; i < 10; i++) begin
            if (ir && !bits[i]) begin
                line_out <= 1'b0;
                repeat (bit_cyc / 16) @(posedge core_clk);
                line_out <= 1'b1;
                repeat (bit_cyc - bit_cyc / 16) @(posedge core_clk);
            end else begin
                line_out <= ir | bits[i];
                repeat (bit_cyc) @(posedge core_clk);
            end
        end
        line_out <= 1'b1;
    endtask : send
    // Frames without a high stop bit are dropped
    always begin
        logic [7:0] b;
        @(negedge wire_lvl);
        repeat (rx_bit / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (rx_bit) @(posedge core_clk);
            b[i] = wire_lvl;
        end
        repeat (rx_bit) @(posedge core_clk);
        if (wire_lvl === 1'b1) got_q.push_back(b);
    end
endmodule : serial_peer_model

/* sim/infrared_async_serial_core_tb_top.sv */
/*
 Self-checking bench: register traffic, transmit frames, normal, break and infrared receive.
 Assumes the peer model on the pins and divisor 0, so a bit lasts 32 core clocks, 64 on the alternate baud source.
*/
`timescale 1ns/1ps
module infrared_async_serial_core_tb_top;
    import serial_core_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, alt_src_tick = 1'b0, rx_line, tx_pin_out, tx_pin_oe, tx_irq, rx_irq;
    bus_req_t bus_req = '0;
    logic [7:0] rd_data, v, d;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    integer seed = 32'h35afd708;
    int exp_q[$];
    infrared_async_serial_core u_infrared_async_serial_core (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus_req(bus_req), .rd_data(rd_data), .alt_src_tick(alt_src_tick), .rx_pin_in(rx_line),
        .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
    serial_peer_model u_serial_peer_model (.core_clk(core_clk), .tx_pin_oe(tx_pin_oe), .line_out(rx_line));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        alt_src_tick <= ~alt_src_tick;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] wd);
        @(posedge core_clk) bus_req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] q);
        @(posedge core_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) bus_req.rd <= 1'b0;
        #1 q = rd_data;
    endtask : rd
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(3'h3, v);
        check("status1 reset", 8'hc0, v);
        check("tx pin idle", 8'h00, {7'h00, tx_pin_oe});
        wr(3'h6, 8'h00);
        wr(3'h0, 8'h40);
        wr(3'h1, 8'h4c);
        for (int k = 0; k < 3; k++) begin
            v = 8'h00;
            for (int i = 0; i < 600 && v[7] !== 1'b1; i++) rd(3'h3, v);
            if (k == 1) begin
                wr(3'h1, 8'h44);
                wr(3'h1, 8'h4c);
            end
            d = 8'($random(seed));
            exp_q.push_back(d);
            wr(3'h5, d);
            if (k == 0) begin
                repeat (3) @(posedge core_clk);
                #1;
                check("tx irq busy", 8'h00, {7'h00, tx_irq});
            end
        end
        for (int i = 0; i < 3000 && u_serial_peer_model.got_q.size() < 3; i++) @(posedge core_clk);
        check("tx count", 8'h03, 8'(u_serial_peer_model.got_q.size()));
        while (exp_q.size() > 0 && u_serial_peer_model.got_q.size() > 0)
            check("tx byte", 8'(exp_q.pop_front()), u_serial_peer_model.got_q.pop_front());
        repeat (40) @(posedge core_clk);
        #1;
        check("tx irq done", 8'h01, {7'h00, tx_irq});
        check("tx pin after", 8'h00, {7'h00, tx_pin_oe});
        check("tx pin drive", 8'h00, {7'h00, tx_pin_out});
        // Break: pin held low, no frame seen by the peer, then an idle character
        wr(3'h1, 8'h2d);
        repeat (40) @(posedge core_clk);
        rd(3'h3, v);
        check("tx done in break", 8'h00, v & 8'h40);
        check("tx pin break", 8'h01, {7'h00, tx_pin_oe});
        wr(3'h1, 8'h2c);
        repeat (800) @(posedge core_clk);
        rd(3'h3, v);
        check("tx done after break", 8'h40, v & 8'h40);
        check("tx pin after break", 8'h00, {7'h00, tx_pin_oe});
        check("break not a frame", 8'h00, 8'(u_serial_peer_model.got_q.size()));
        // Modes: 0 plain byte, 1 break, 2 infrared pulses on the alternate baud source
        for (int m = 0; m < 3; m++) begin
            if (m == 2) begin
                wr(3'h7, 8'h01);
                wr(3'h6, 8'h80);
            end
            d = (m == 1) ? 8'h00 : ((m == 2) ? 8'h55 : 8'($random(seed)));
            u_serial_peer_model.send((m == 1) ? 10'h000 : {1'b1, d, 1'b0}, (m == 2) ? 64 : 32, m == 2);
            for (int i = 0; i < 200 && rx_irq !== 1'b1; i++) @(posedge core_clk);
            #1;
            check("rx irq", 8'h01, {7'h00, rx_irq});
            rd(3'h3, v);
            check("status1 rx", (m == 1) ? 8'h22 : 8'h20, v & 8'h22);
            rd(3'h4, v);
            check("status2 break", (m == 1) ? 8'h02 : 8'h00, v & 8'h02);
            rd(3'h2, v);
            check("rx ninth", {d[7], 7'h00}, v & 8'h80);
            rd(3'h5, v);
            check("rx data", d, v);
            repeat (3) @(posedge core_clk);
            #1;
            check("rx irq clear", 8'h00, {7'h00, rx_irq});
        end
        conclude();
    end
endmodule : infrared_async_serial_core_tb_top
